// [timer_counter_regs.svh]
// Purpose: Register offsets, field positions, reset values and divider taps of the timer.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register.
// Notes: Included by every design file of the timer except the package.
`ifndef TIMER_COUNTER_REGS_SVH
`define TIMER_COUNTER_REGS_SVH

// Register indices; odd indices exist, so each index is one 32-bit word
`define TMR_IDX_COMPARE_A 12'h010
`define TMR_IDX_CAPTURE_B 12'h012
`define TMR_IDX_CONTROL 12'h014
`define TMR_IDX_SYSCTL 12'h015
`define TMR_IDX_STATUS 12'h016

// Register byte addresses: four times the index
`define TMR_OFS_COMPARE_A 12'h040
`define TMR_OFS_CAPTURE_B 12'h048
`define TMR_OFS_CONTROL 12'h050
`define TMR_OFS_SYSCTL 12'h054
`define TMR_OFS_STATUS 12'h058

// Control register fields
`define TMR_CTL_FF_BIT 7
`define TMR_CTL_OPT_BIT 6
`define TMR_CTL_START_HI 5
`define TMR_CTL_START_LO 4
`define TMR_CTL_CLK_HI 3
`define TMR_CTL_CLK_LO 2
`define TMR_CTL_MODE_HI 1
`define TMR_CTL_MODE_LO 0

// System control fields
`define TMR_SYS_STOP_BIT 0
`define TMR_SYS_SLOW_BIT 1
`define TMR_SYS_DIVOPT_BIT 2

// Reset values
`define TMR_CONTROL_RESET 8'h00
`define TMR_DATA_RESET 16'hffff

// Prescaler taps: high clock /2^11, /2^7, /2^3 and low clock /2^3
`define TMR_TAP_HI_11 10
`define TMR_TAP_HI_7 6
`define TMR_TAP_HI_3 2
`define TMR_TAP_LO_3 2
`define TMR_PRESCALE_W 11
`define TMR_LOWDIV_W 3

`endif

// [timer_counter_pkg.sv]
// Purpose: Types shared by the timer files.
// Assumes: Constants live in timer_counter_regs.svh.
// Notes: Nothing here is imported; every use is scoped.
package timer_counter_pkg;

   typedef enum logic [1:0] {
      MODE_TIMER = 2'h0,
      MODE_WINDOW = 2'h1,
      MODE_PULSE_WIDTH = 2'h2,
      MODE_PULSE_OUT = 2'h3
   } mode_type;

   typedef enum logic [1:0] {
      START_STOP = 2'h0,
      START_COMMAND = 2'h1,
      START_RISING = 2'h2,
      START_FALLING = 2'h3
   } start_type;

   typedef enum logic [1:0] {
      CLK_SLOW = 2'h0,
      CLK_MID = 2'h1,
      CLK_FAST = 2'h2,
      CLK_PIN = 2'h3
   } clock_sel_type;

   typedef struct packed {
      logic flipflop_initial_level;
      logic mode_option;
      start_type start_control;
      clock_sel_type source_clock_select;
      mode_type operating_mode_select;
   } control_type;

   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } data_word_type;

endpackage

// [timer_prescaler.sv]
// Purpose: Free-running dividers that give one-cycle tick pulses.
// Assumes: hi_clk_en_i and lo_clk_en_i are one-cycle enables of the two system clocks.
// Notes: Tick is the falling edge of the selected divider bit.
`timescale 1ns/1ps
`include "timer_counter_regs.svh"

module timer_prescaler (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Clock enables
   input wire logic hi_clk_en_i,
   input wire logic lo_clk_en_i,
   // Ticks
   output logic tick_hi11_o,
   output logic tick_hi7_o,
   output logic tick_hi3_o,
   output logic tick_lo3_o
);

   logic [`TMR_PRESCALE_W-1:0] hi_q;
   logic [`TMR_LOWDIV_W-1:0] lo_q;
   wire [`TMR_PRESCALE_W-1:0] hi_next = hi_q + 1'b1;
   wire [`TMR_LOWDIV_W-1:0] lo_next = lo_q + 1'b1;

   // Tick when the tap bit wraps from 1 to 0, once per divided period
   assign tick_hi11_o = hi_clk_en_i && hi_q[`TMR_TAP_HI_11] && !hi_next[`TMR_TAP_HI_11];
   assign tick_hi7_o = hi_clk_en_i && hi_q[`TMR_TAP_HI_7] && !hi_next[`TMR_TAP_HI_7];
   assign tick_hi3_o = hi_clk_en_i && hi_q[`TMR_TAP_HI_3] && !hi_next[`TMR_TAP_HI_3];
   assign tick_lo3_o = lo_clk_en_i && lo_q[`TMR_TAP_LO_3] && !lo_next[`TMR_TAP_LO_3];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         hi_q <= '0;
         lo_q <= '0;
      end else begin
         if (hi_clk_en_i) hi_q <= hi_next;
         if (lo_clk_en_i) lo_q <= lo_next;
      end
   end

endmodule

// [timer_data_reg.sv]
// Purpose: One double-buffered 16-bit timer register with byte-wide staging.
// Assumes: Upper byte write arms the transfer; lower byte alone never does.
// Notes: Active value moves on the first source tick after the upper byte write.
`timescale 1ns/1ps
`include "timer_counter_regs.svh"

module timer_data_reg (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Software side
   input wire logic wr_lo_i,
   input wire logic wr_hi_i,
   input wire logic [7:0] wdata_lo_i,
   input wire logic [7:0] wdata_hi_i,
   // Timer side
   input wire logic tick_i,
   input wire logic capture_i,
   input wire logic [15:0] capture_val_i,
   output logic [15:0] active_o
);

   timer_counter_pkg::data_word_type stage_q;
   logic armed_q;
   logic [15:0] active_q;

   assign active_o = active_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stage_q <= `TMR_DATA_RESET;
         armed_q <= 1'b0;
         active_q <= `TMR_DATA_RESET;
      end else begin
         if (wr_lo_i) stage_q.lower <= wdata_lo_i;
         if (wr_hi_i) stage_q.upper <= wdata_hi_i;
         // Arm wins over the tick so a write in the tick cycle waits for the next
         if (wr_hi_i) armed_q <= 1'b1;
         else if (tick_i) armed_q <= 1'b0;
         if (tick_i && armed_q && !wr_hi_i) active_q <= stage_q;
         else if (capture_i) active_q <= capture_val_i;
      end
   end

endmodule

// [timer_counter_top.sv]
// What this block does
// - Two 16-bit timer registers, byte addressable
// - Register B writable only in pulse output
// - Bit 6 enables auto-capture in timer/event/window
// - Bit 6 selects per-mode option elsewhere
// - Stop clears counter; command start timer/pulse output only
// - Pin edges start or count; pin level gates
// - Source clock from prescaler taps or pin
// - Mode field picks one of four modes
// - New value active at tick after upper write
// - Lower byte alone never updates register
// - Stop state forces start field to stop
// - Capture counter into B each source tick
// - Timer match raises interrupt, clears; stops if edge-started on a prescaler clock
//
// Purpose: Control and compare/capture registers of a 16-bit timer with AXI4-Lite access.
// Assumes: Pin, stop and clock enables are synchronous to CLK_I.
// Notes: Detailed window, pulse width and pulse output waveforms are not built here.
`timescale 1ns/1ps
`include "timer_counter_regs.svh"

module timer_counter_top (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // System clock enables
   input wire logic HI_CLK_EN_I,
   input wire logic LO_CLK_EN_I,
   // Timer pin and power state
   input wire logic TIMER_PIN_I,
   input wire logic STOP_ENTRY_I,
   // AXI4-Lite write address
   input wire logic [11:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   // AXI4-Lite write data
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // AXI4-Lite read address
   input wire logic [11:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   // AXI4-Lite read data
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // Timer outputs
   output logic TIMER_MATCH_INTERRUPT_O,
   output logic TIMER_FLIPFLOP_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus write channel

   logic aw_hold_q;
   logic w_hold_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic awready_q;
   logic wready_q;

   wire aw_take = S_AXI_AWVALID_I && awready_q;
   wire w_take = S_AXI_WVALID_I && wready_q;
   wire wr_go = aw_hold_q && w_hold_q && !bvalid_q;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR_I;
         end else if (wr_go) begin
            aw_hold_q <= 1'b0;
         end
         if (w_take) begin
            w_hold_q <= 1'b1;
            wdata_q <= S_AXI_WDATA_I;
            wstrb_q <= S_AXI_WSTRB_I;
         end else if (wr_go) begin
            w_hold_q <= 1'b0;
         end
         // One write in flight; ready stays low from each take until the second cycle after the response is accepted
         awready_q <= !aw_hold_q && !aw_take && !wr_go && !bvalid_q;
         wready_q <= !w_hold_q && !w_take && !wr_go && !bvalid_q;
      end
   end

   wire wsel_a = (awaddr_q == `TMR_OFS_COMPARE_A);
   wire wsel_b = (awaddr_q == `TMR_OFS_CAPTURE_B);
   wire wsel_ctl = (awaddr_q == `TMR_OFS_CONTROL);
   wire wsel_sys = (awaddr_q == `TMR_OFS_SYSCTL);
   wire wsel_sts = (awaddr_q == `TMR_OFS_STATUS);
   wire wr_mapped = wsel_a || wsel_b || wsel_ctl || wsel_sys || wsel_sts;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         bvalid_q <= 1'b0;
         bresp_q <= 2'h0;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_mapped ? 2'h0 : 2'h2;
      end else if (S_AXI_BREADY_I) begin
         bvalid_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control and system registers

   timer_counter_pkg::control_type ctl_q;
   logic [2:0] sys_q;
   wire is_pulse_out = (ctl_q.operating_mode_select == timer_counter_pkg::MODE_PULSE_OUT);
   wire ctl_wr = wr_go && wsel_ctl && wstrb_q[0];
   wire sys_wr = wr_go && wsel_sys && wstrb_q[0];
   wire div_opt = sys_q[`TMR_SYS_DIVOPT_BIT] || sys_q[`TMR_SYS_SLOW_BIT];

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctl_q <= `TMR_CONTROL_RESET;
         sys_q <= '0;
      end else begin
         if (ctl_wr) ctl_q <= wdata_q[7:0];
         if (sys_wr) sys_q <= wdata_q[2:0];
         // Stop entry overrides the start field of a control write in the same cycle
         if (STOP_ENTRY_I || (sys_wr && wdata_q[`TMR_SYS_STOP_BIT]))
            ctl_q.start_control <= timer_counter_pkg::START_STOP;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source clock selection

   logic tick_hi11;
   logic tick_hi7;
   logic tick_hi3;
   logic tick_lo3;
   logic pin_q;

   timer_prescaler u_prescaler (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .hi_clk_en_i(HI_CLK_EN_I),
      .lo_clk_en_i(LO_CLK_EN_I),
      .tick_hi11_o(tick_hi11),
      .tick_hi7_o(tick_hi7),
      .tick_hi3_o(tick_hi3),
      .tick_lo3_o(tick_lo3)
   );

   wire pin_rise = TIMER_PIN_I && !pin_q;
   wire pin_fall = !TIMER_PIN_I && pin_q;
   wire edge_falling = (ctl_q.start_control == timer_counter_pkg::START_FALLING);
   wire pin_edge = edge_falling ? pin_fall : pin_rise;
   wire pin_edge_opp = edge_falling ? pin_rise : pin_fall;

   logic src_tick;
   always_comb begin
      case (ctl_q.source_clock_select)
         timer_counter_pkg::CLK_SLOW: src_tick = div_opt ? tick_lo3 : tick_hi11;
         timer_counter_pkg::CLK_MID: src_tick = tick_hi7;
         timer_counter_pkg::CLK_FAST: src_tick = tick_hi3;
         default: src_tick = pin_edge;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer registers

   logic [15:0] reg_a;
   logic [15:0] reg_b;
   logic [15:0] count_q;
   logic cap_q;

   wire a_wr_lo = wr_go && wsel_a && wstrb_q[0];
   wire a_wr_hi = wr_go && wsel_a && wstrb_q[1];
   wire b_ok = wr_go && wsel_b && is_pulse_out;
   wire b_wr_lo = b_ok && wstrb_q[0];
   wire b_wr_hi = b_ok && wstrb_q[1];

   // Capture allowed only in timer, event and window modes
   wire cap_mode = (ctl_q.operating_mode_select == timer_counter_pkg::MODE_TIMER)
                   || (ctl_q.operating_mode_select == timer_counter_pkg::MODE_WINDOW);
   wire capture_on = ctl_q.mode_option && cap_mode;
   wire capture = capture_on && src_tick;

   timer_data_reg u_reg_a (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .wr_lo_i(a_wr_lo),
      .wr_hi_i(a_wr_hi),
      .wdata_lo_i(wdata_q[7:0]),
      .wdata_hi_i(wdata_q[15:8]),
      .tick_i(src_tick),
      .capture_i(1'b0),
      .capture_val_i(16'h0000),
      .active_o(reg_a)
   );

   timer_data_reg u_reg_b (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .wr_lo_i(b_wr_lo),
      .wr_hi_i(b_wr_hi),
      .wdata_lo_i(wdata_q[7:0]),
      .wdata_hi_i(wdata_q[15:8]),
      .tick_i(src_tick),
      .capture_i(capture),
      .capture_val_i(count_q),
      .active_o(reg_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Up-counter

   logic running_q;
   logic irq_q;
   logic ff_q;
   wire stopped = (ctl_q.start_control == timer_counter_pkg::START_STOP);
   wire cmd_start = (ctl_q.start_control == timer_counter_pkg::START_COMMAND);
   wire cmd_ok = cmd_start && (ctl_q.operating_mode_select == timer_counter_pkg::MODE_TIMER
                               || is_pulse_out);
   wire pin_clocked = (ctl_q.source_clock_select == timer_counter_pkg::CLK_PIN);
   wire gate_level = edge_falling ? !TIMER_PIN_I : TIMER_PIN_I;
   wire is_window = (ctl_q.operating_mode_select == timer_counter_pkg::MODE_WINDOW);
   // Pin-clocked counting in mode 00 is event counting: no start edge needed
   wire free_run = cmd_ok || (pin_clocked && !cmd_start && !is_window);
   wire trigger = !cmd_start && !pin_clocked && pin_edge;
   wire count_en = running_q && (!is_window || gate_level);
   // No match while stopped, so after stop entry only a match in the entry cycle itself still raises an interrupt, one cycle later
   wire match = !stopped && count_en && src_tick && (count_q == reg_a);
   wire trig_stop = ctl_q.mode_option && !is_window && !free_run && pin_edge_opp;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pin_q <= 1'b0;
         count_q <= '0;
         running_q <= 1'b0;
         irq_q <= 1'b0;
         ff_q <= 1'b0;
      end else begin
         pin_q <= TIMER_PIN_I;
         irq_q <= match;
         if (stopped) begin
            count_q <= '0;
            running_q <= 1'b0;
            ff_q <= ctl_q.flipflop_initial_level;
         end else if (free_run) begin
            running_q <= 1'b1;
            if (match) count_q <= '0;
            else if (count_en && src_tick) count_q <= count_q + 16'h0001;
         end else if (match) begin
            count_q <= '0;
            running_q <= 1'b0;
            ff_q <= !ff_q;
         end else if (running_q && trig_stop) begin
            count_q <= '0;
            running_q <= 1'b0;
         end else if (trigger && !running_q) begin
            running_q <= 1'b1;
         end else if (count_en && src_tick) begin
            count_q <= count_q + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus read channel

   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   wire ar_take = S_AXI_ARVALID_I && arready_q;
   wire [31:0] status_word = {13'h0000, running_q, ff_q, is_pulse_out, count_q};

   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (S_AXI_ARADDR_I)
         `TMR_OFS_COMPARE_A: rd_mux = {16'h0000, reg_a};
         `TMR_OFS_CAPTURE_B: rd_mux = {16'h0000, reg_b};
         `TMR_OFS_CONTROL: rd_mux = {24'h000000, ctl_q};
         `TMR_OFS_SYSCTL: rd_mux = {29'h00000000, sys_q};
         `TMR_OFS_STATUS: rd_mux = status_word;
         default: begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= 2'h0;
      end else begin
         arready_q <= !arready_q && !rvalid_q && !ar_take;
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? 2'h0 : 2'h2;
         end else if (S_AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign S_AXI_AWREADY_O = awready_q;
   assign S_AXI_WREADY_O = wready_q;
   assign S_AXI_BVALID_O = bvalid_q;
   assign S_AXI_BRESP_O = bresp_q;
   assign S_AXI_ARREADY_O = arready_q;
   assign S_AXI_RVALID_O = rvalid_q;
   assign S_AXI_RDATA_O = rdata_q;
   assign S_AXI_RRESP_O = rresp_q;
   assign TIMER_MATCH_INTERRUPT_O = irq_q;
   assign TIMER_FLIPFLOP_O = ff_q;

endmodule

// [timer_counter_top_monitor.sv]
// Purpose: Concurrent checks on the ports of the timer register block.
// Assumes: One clock domain, reset active high.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module timer_counter_top_monitor (
   // Clock, reset and power state
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic STOP_ENTRY_I,
   // Write channels
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // Read channels
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic [1:0] S_AXI_RRESP_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // Timer
   input wire logic TIMER_MATCH_INTERRUPT_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   sequence s_wr_taken;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   endsequence
   sequence s_rd_taken;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_wr_answer: assert property (s_wr_taken |-> ##[1:2] S_AXI_BVALID_O)
      else $error("write response late");
   a_bvalid_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
      S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
   a_wr_blocked: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
      else $error("write taken while response pending");
   a_rd_answer: assert property (s_rd_taken |=> S_AXI_RVALID_O)
      else $error("read data late");
   a_rvalid_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
      S_AXI_RVALID_O && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O))
      else $error("read data changed before taken");
   a_rd_single: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read taken while data pending");
   a_resp_legal: assert property (S_AXI_RVALID_O |-> S_AXI_RRESP_O inside {2'h0, 2'h2})
      else $error("illegal read response");
   a_irq_pulse: assert property (TIMER_MATCH_INTERRUPT_O |=> !TIMER_MATCH_INTERRUPT_O)
      else $error("match interrupt longer than one cycle");
   a_stop_quiet: assert property (STOP_ENTRY_I [*2] |=> !TIMER_MATCH_INTERRUPT_O)
      else $error("match interrupt in stop state");
endmodule
bind timer_counter_top timer_counter_top_monitor i_mon (.CLK_I(CLK_I), .RST_I(RST_I),
   .STOP_ENTRY_I(STOP_ENTRY_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
   .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
   .TIMER_MATCH_INTERRUPT_O(TIMER_MATCH_INTERRUPT_O));

// [timer_far_side_model.sv]
// Purpose: Far side of the timer: timer pin pulses and low clock ticks.
// Assumes: Pin idles low between pulses.
// Notes: Low clock tick every fourth cycle.
`timescale 1ns/1ps
module timer_far_side_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // To the timer
   output logic pin_o,
   output logic lo_en_o
);
   logic [1:0] div_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end
   assign lo_en_o = (div_q == 2'h0);
   initial pin_o = 1'b0;
   // Wide levels, so any pin filter still sees both edges
   task automatic send(input int n);
      repeat (n) begin
         @(posedge clk_i);
         pin_o <= 1'b1;
         repeat (6) @(posedge clk_i);
         pin_o <= 1'b0;
         repeat (6) @(posedge clk_i);
      end
   endtask
endmodule

// [timer_counter_control_regs_tb.sv]
// Purpose: Self-checking bench of the timer control and data registers.
// Assumes: High clock enable held at one, so the high clock equals CLK_I.
// Notes: Tick counts allow one tick of slack for the free prescaler phase.
`timescale 1ns/1ps
`include "timer_counter_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module timer_counter_control_regs_tb;
   logic clk, rst, stop_in, awvalid, wvalid, bready, arvalid, rready;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata_v;
   logic [3:0] wstrb;
   logic [1:0] bresp_v, rresp_v;
   wire awready, wready, bvalid, arready, rvalid, irq, tff, lo_en, pin;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int fail_count, total_checks, cycles, irq_count;
   timer_counter_top i_timer_counter_top (.CLK_I(clk), .RST_I(rst), .HI_CLK_EN_I(1'b1),
      .LO_CLK_EN_I(lo_en), .TIMER_PIN_I(pin), .STOP_ENTRY_I(stop_in),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .TIMER_MATCH_INTERRUPT_O(irq), .TIMER_FLIPFLOP_O(tff));
   timer_far_side_model i_far_side (.clk_i(clk), .rst_i(rst), .pin_o(pin), .lo_en_o(lo_en));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (irq === 1'b1) irq_count++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (!aw_done && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      // Ready raised a cycle after the take, as the response goes valid
      @(posedge clk);
      bready <= 1'b1;
      do @(posedge clk); while (bvalid !== 1'b1);
      bresp_v = bresp;
      bready <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      axi_write(a, d, 4'h3);
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (rvalid !== 1'b1);
      rdata_v = rdata;
      rresp_v = rresp;
      rready <= 1'b0;
   endtask
   task automatic set_ctrl(input logic [7:0] v);
      wr(`TMR_OFS_CONTROL, {24'h0, v & 8'hcf});
      wr(`TMR_OFS_CONTROL, {24'h0, v});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      rd(`TMR_OFS_CONTROL);
      `CHK(rdata_v, 32'h0000_0000)
      rd(`TMR_OFS_COMPARE_A);
      `CHK(rdata_v, 32'h0000_ffff)
      rd(`TMR_OFS_CAPTURE_B);
      `CHK(rdata_v, 32'h0000_ffff)
      rd(12'h100);
      `CHK({rresp_v, rdata_v}, {2'h2, 32'h0})
      wr(12'h100, 32'h0);
      `CHK(bresp_v, 2'h2)
   endtask
   task automatic t_data_regs();
      set_ctrl(8'h08);
      axi_write(`TMR_OFS_COMPARE_A, 32'h0000_0034, 4'h1);
      wt(40);
      rd(`TMR_OFS_COMPARE_A);
      `CHK(rdata_v[15:0], 16'hffff)
      axi_write(`TMR_OFS_COMPARE_A, 32'h0000_1200, 4'h2);
      wt(20);
      rd(`TMR_OFS_COMPARE_A);
      `CHK(rdata_v[15:0], 16'h1234)
   endtask
   task automatic t_reg_b_access();
      wr(`TMR_OFS_CAPTURE_B, 32'h3);
      wt(20);
      rd(`TMR_OFS_CAPTURE_B);
      `CHK(rdata_v[15:0], 16'hffff)
      set_ctrl(8'h8b);
      wt(4);
      `CHK(tff, 1'b1)
      wr(`TMR_OFS_CAPTURE_B, 32'h3);
      wt(20);
      rd(`TMR_OFS_CAPTURE_B);
      `CHK(rdata_v[15:0], 16'h0003)
      set_ctrl(8'h08);
   endtask
   task automatic t_timer_match();
      int n;
      wr(`TMR_OFS_COMPARE_A, 32'h4);
      set_ctrl(8'h18);
      n = irq_count;
      wt(200);
      `CHK((irq_count - n) inside {[4:7]}, 1'b1)
      set_ctrl(8'h08);
      rd(`TMR_OFS_STATUS);
      `CHK(rdata_v[15:0], 16'h0000)
      set_ctrl(8'h18);
      wt(30);
      stop_in <= 1'b1;
      wt(2);
      stop_in <= 1'b0;
      wt(2);
      rd(`TMR_OFS_CONTROL);
      `CHK(rdata_v[7:0], 8'h08)
      n = irq_count;
      wt(100);
      `CHK(irq_count - n, 0)
   endtask
   task automatic t_capture();
      logic [15:0] b1;
      wr(`TMR_OFS_COMPARE_A, 32'h100);
      set_ctrl(8'h58);
      wt(24);
      rd(`TMR_OFS_CAPTURE_B);
      b1 = rdata_v[15:0];
      wt(40);
      rd(`TMR_OFS_CAPTURE_B);
      `CHK(b1 < 16'h0100, 1'b1)
      `CHK((rdata_v[15:0] - b1) inside {[4:7]}, 1'b1)
      set_ctrl(8'h08);
   endtask
   task automatic t_clock_select();
      logic [7:0] ctl [4] = '{8'h10, 8'h10, 8'h14, 8'h18};
      logic [2:0] sys [4] = '{3'h4, 3'h2, 3'h0, 3'h0};
      int per [4] = '{32, 32, 128, 8};
      int e;
      wr(`TMR_OFS_COMPARE_A, 32'h0fff);
      for (int i = 0; i < 4; i++) begin
         wr(`TMR_OFS_SYSCTL, {29'h0, sys[i]});
         set_ctrl(ctl[i]);
         wt(320);
         rd(`TMR_OFS_STATUS);
         e = 320 / per[i];
         `CHK(int'(rdata_v[15:0]) inside {[e - 1:e + 1]}, 1'b1)
         set_ctrl(ctl[i] & 8'hcf);
      end
      wr(`TMR_OFS_SYSCTL, 32'h0);
   endtask
   task automatic t_trigger();
      int n;
      wr(`TMR_OFS_COMPARE_A, 32'h4);
      set_ctrl(8'h28);
      n = irq_count;
      wt(100);
      `CHK(irq_count - n, 0)
      i_far_side.send(1);
      wt(60);
      `CHK(irq_count - n, 1)
      set_ctrl(8'h08);
   endtask
   task automatic t_event();
      wr(`TMR_OFS_COMPARE_A, 32'hff);
      set_ctrl(8'h2c);
      i_far_side.send(5);
      wt(10);
      rd(`TMR_OFS_STATUS);
      `CHK(rdata_v[15:0], 16'h0005)
      set_ctrl(8'h3c);
      i_far_side.send(3);
      wt(10);
      rd(`TMR_OFS_STATUS);
      `CHK(rdata_v[15:0], 16'h0003)
      set_ctrl(8'h0c);
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {stop_in, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata, wstrb} = 60'h0;
      wt(4);
      rst <= 1'b0;
      wt(2);
      t_reset_values();
      t_data_regs();
      t_reg_b_access();
      t_timer_match();
      t_capture();
      t_clock_select();
      t_trigger();
      t_event();
      final_report();
   end
endmodule
